// ==== core/scan_dff_async_set_reset.sv ====
`timescale 1ns/1ps

// The cell is modelled inside the core clock domain. The cell clock and the
// asynchronous controls arrive as pins, are sampled and filtered, and the
// cell state reacts one core cycle after the filtered level is seen. That
// trades a few core cycles of latency for a design that has a single clock
// and no reset paths driven from logic.
module scan_dff_async_set_reset #(
  parameter bit HAS_SCAN = 1'b1,
  parameter bit HAS_CLEAR = 1'b1,
  parameter bit HAS_INVERTED = 1'b1
)(
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // cell clock from the surrounding logic
  input wire logic EDGE_CLOCK,
  // functional and scan data
  input wire logic DATA_IN,
  input wire logic SCAN_SERIAL_IN,
  input wire logic SCAN_SELECT,
  // asynchronous controls, active low
  input wire logic ASYNC_PRESET_LOW,
  input wire logic ASYNC_CLEAR_LOW,
  // cell outputs
  output logic TRUE_OUT,
  output logic INVERTED_OUT
);

  logic [ff_cell_pkg::PIN_COUNT-1:0] raw_pins;
  logic [ff_cell_pkg::PIN_COUNT-1:0] pins;
  logic clock_seen;
  logic next_clock_seen;
  logic clock_rise;
  logic preset_low;
  logic clear_low;
  logic scan_on;
  logic capture_bit;
  logic next_true;
  logic next_inverted;
  ff_cell_pkg::action_t action;

  // pick the bit that a clock edge loads; without a scan path the select
  // pin is ignored entirely so a floating select cannot upset the cell
  function automatic logic pick_capture(
    input logic use_scan,
    input logic data_bit,
    input logic scan_bit
  );
    pick_capture = use_scan ? scan_bit : data_bit;
  endfunction

  // priority decode of the async controls ahead of the clock edge; the
  // controls are levels, so they win on every cycle they are held low
  function automatic ff_cell_pkg::action_t decode_action(
    input logic pre_low,
    input logic clr_low,
    input logic rise
  );
    if (pre_low && clr_low)
      decode_action = ff_cell_pkg::ACT_BOTH;
    else if (pre_low)
      decode_action = ff_cell_pkg::ACT_PRESET;
    else if (clr_low)
      decode_action = ff_cell_pkg::ACT_CLEAR;
    else if (rise)
      decode_action = ff_cell_pkg::ACT_CAPTURE;
    else
      decode_action = ff_cell_pkg::ACT_HOLD;
  endfunction

  // gather the pins into one vector for the sampler
  always_comb
  begin
    raw_pins = '0;
    raw_pins[ff_cell_pkg::PIN_CLOCK] = EDGE_CLOCK;
    raw_pins[ff_cell_pkg::PIN_DATA] = DATA_IN;
    raw_pins[ff_cell_pkg::PIN_SCAN_IN] = SCAN_SERIAL_IN;
    raw_pins[ff_cell_pkg::PIN_SCAN_SEL] = SCAN_SELECT;
    raw_pins[ff_cell_pkg::PIN_PRESET_LOW] = ASYNC_PRESET_LOW;
    raw_pins[ff_cell_pkg::PIN_CLEAR_LOW] = ASYNC_CLEAR_LOW;
  end

  // all pins share one filter so data keeps its relation to the clock edge
  pin_filter #(
    .WIDTH(ff_cell_pkg::PIN_COUNT),
    .RESET_VALUE(ff_cell_pkg::PIN_RESET)
  ) u_pin_filter (
    .clk(CORE_CLK),
    .rst(RST),
    .pins(raw_pins),
    .filtered(pins)
  );

  // variant options: a missing pin reads as its idle level
  always_comb
  begin
    preset_low = ~pins[ff_cell_pkg::PIN_PRESET_LOW];
    clear_low = HAS_CLEAR & ~pins[ff_cell_pkg::PIN_CLEAR_LOW];
    scan_on = HAS_SCAN & pins[ff_cell_pkg::PIN_SCAN_SEL];
  end

  // edge detector on the filtered cell clock
  always_comb
  begin
    next_clock_seen = pins[ff_cell_pkg::PIN_CLOCK];
    clock_rise = pins[ff_cell_pkg::PIN_CLOCK] & ~clock_seen;
  end

  // capture source: functional data or scan input
  always_comb
  begin
    capture_bit = pick_capture(scan_on,
                               pins[ff_cell_pkg::PIN_DATA],
                               pins[ff_cell_pkg::PIN_SCAN_IN]);
    action = decode_action(preset_low, clear_low, clock_rise);
  end

  // next output values; the async cases do not look at the clock edge
  always_comb
  begin
    next_true = TRUE_OUT;
    next_inverted = INVERTED_OUT;
    case (action)
      ff_cell_pkg::ACT_BOTH:
      begin
        // outputs stop being complementary while both are held
        next_true = 1'b0;
        next_inverted = 1'b0;
      end
      ff_cell_pkg::ACT_PRESET:
      begin
        next_true = 1'b1;
        next_inverted = 1'b0;
      end
      ff_cell_pkg::ACT_CLEAR:
      begin
        next_true = 1'b0;
        next_inverted = 1'b1;
      end
      ff_cell_pkg::ACT_CAPTURE:
      begin
        next_true = capture_bit;
        next_inverted = ~capture_bit;
      end
      ff_cell_pkg::ACT_HOLD:
      begin
        next_true = TRUE_OUT;
        next_inverted = INVERTED_OUT;
      end
      default:
      begin
        next_true = TRUE_OUT;
        next_inverted = INVERTED_OUT;
      end
    endcase
    // true-only variant: inverted pin held low, true path unchanged
    if (!HAS_INVERTED)
      next_inverted = 1'b0;
  end

  // register cell state and clock history; reset loads constants only
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      clock_seen <= ff_cell_pkg::CLOCK_SEEN_RESET;
      TRUE_OUT <= ff_cell_pkg::TRUE_RESET;
      INVERTED_OUT <= HAS_INVERTED ? ff_cell_pkg::INVERTED_RESET : 1'b0;
    end
    else
    begin
      clock_seen <= next_clock_seen;
      TRUE_OUT <= next_true;
      INVERTED_OUT <= next_inverted;
    end
  end

endmodule // scan_dff_async_set_reset

// ==== core/ff_cell_pkg.sv ====
package ff_cell_pkg;

  // core clock figures, kept for reference by the timing notes
  localparam int CORE_CLK_PERIOD_NS = 5;

  // every pin input passes this many flip-flops before it is believed
  localparam int SYNC_STAGES = 3;

  // bit positions of the cell pins inside the sampled pin vector
  localparam int PIN_COUNT = 6;
  localparam int PIN_CLOCK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_SCAN_IN = 2;
  localparam int PIN_SCAN_SEL = 3;
  localparam int PIN_PRESET_LOW = 4;
  localparam int PIN_CLEAR_LOW = 5;

  // pin vector after reset: clock low, data low, both async controls idle
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h30;

  // stored outputs after reset: a cleared cell
  localparam logic TRUE_RESET = 1'h0;
  localparam logic INVERTED_RESET = 1'h1;
  localparam logic CLOCK_SEEN_RESET = 1'h0;

  // what the cell does on a given core clock cycle, highest priority first
  typedef enum logic [2:0] {
    ACT_BOTH,
    ACT_PRESET,
    ACT_CLEAR,
    ACT_CAPTURE,
    ACT_HOLD
  } action_t;

endpackage

// ==== core/pin_filter.sv ====
`timescale 1ns/1ps

// three-stage sampler for pins from outside the core clock domain; a level
// is accepted only once the second and third stages agree, so a one-cycle
// glitch that slips past the first stage never reaches the cell state
module pin_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins and accepted levels
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] filtered
);

  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] stage_c;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] next_filtered;

  // stage_a is read by stage_b only; the agreement test looks at b and c
  always_comb
  begin
    agree = ~(stage_b ^ stage_c);
    next_filtered = (stage_b & agree) | (filtered & ~agree);
  end

  // register stages; async reset loads constants only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage_a <= RESET_VALUE;
      stage_b <= RESET_VALUE;
      stage_c <= RESET_VALUE;
      filtered <= RESET_VALUE;
    end
    else
    begin
      stage_a <= pins;
      stage_b <= stage_a;
      stage_c <= stage_b;
      filtered <= next_filtered;
    end
  end

endmodule // pin_filter

// ==== testbench/ff_cell_chk.sv ====
`timescale 1ns/1ps

// pin-level checker; every figure follows the four-edge sampler latency
module ff_cell_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // cell pins
  input wire logic EDGE_CLOCK,
  input wire logic DATA_IN,
  input wire logic SCAN_SERIAL_IN,
  input wire logic SCAN_SELECT,
  input wire logic ASYNC_PRESET_LOW,
  input wire logic ASYNC_CLEAR_LOW,
  input wire logic TRUE_OUT,
  input wire logic INVERTED_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // both controls idle
  wire hi = ASYNC_PRESET_LOW && ASYNC_CLEAR_LOW;

  chk_preset_force: assert property (
    (!ASYNC_PRESET_LOW && ASYNC_CLEAR_LOW) [*5] |=> TRUE_OUT && !INVERTED_OUT)
    else $error("preset did not force 1/0");
  chk_clear_force: assert property (
    (ASYNC_PRESET_LOW && !ASYNC_CLEAR_LOW) [*5] |=> !TRUE_OUT && INVERTED_OUT)
    else $error("clear did not force 0/1");
  chk_both_low: assert property (
    (!ASYNC_PRESET_LOW && !ASYNC_CLEAR_LOW) [*5] |=> !TRUE_OUT && !INVERTED_OUT)
    else $error("both low did not give 0/0");
  chk_hold_value: assert property (
    (hi && !$rose(EDGE_CLOCK)) [*6] |=> $stable(TRUE_OUT) && $stable(INVERTED_OUT))
    else $error("outputs moved without a cause");
  chk_capture_data: assert property (
    $rose(EDGE_CLOCK) ##0 (hi && !SCAN_SELECT) [*5]
    |=> TRUE_OUT == $past(DATA_IN, 5))
    else $error("data not captured");
  chk_capture_scan: assert property (
    $rose(EDGE_CLOCK) ##0 (hi && SCAN_SELECT) [*5]
    |=> TRUE_OUT == $past(SCAN_SERIAL_IN, 5))
    else $error("scan input not captured");
  chk_no_early: assert property (
    (hi && !EDGE_CLOCK) [*4] ##1 ($rose(EDGE_CLOCK) && hi)
    |=> $stable(TRUE_OUT) [*4])
    else $error("output changed before the sampler latency");
  chk_out_complement: assert property (
    hi [*6] ##1 $changed(TRUE_OUT) |-> INVERTED_OUT == !TRUE_OUT)
    else $error("captured outputs not complementary");
endmodule // ff_cell_chk

// ==== testbench/pin_source.sv ====
`timescale 1ns/1ps

// surrounding logic: launches commanded pin levels on the falling edge,
// half a cycle clear of the sampling edge
module pin_source (
  // clock
  input wire logic clk,
  // commanded and launched pins {clear, preset, select, scan, data, clock}
  input wire logic [5:0] cmd,
  output logic [5:0] pins
);
  initial pins = 6'h30;
  always @(negedge clk) pins <= cmd;
endmodule // pin_source

// ==== testbench/test_scan_dff_async_set_reset.sv ====
`timescale 1ns/1ps

// table of single operations, then a clock edge lost under preset
module test_scan_dff_async_set_reset;
  // op 0 capture, 1 preset, 2 clear, 3 both
  typedef struct {logic [1:0] op; logic d; logic s; logic sel;
    logic q; logic qn;} row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [5:0] cmd = 6'h30;
  logic [5:0] pins;
  logic q;
  logic qn;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  row_t rows [8] = '{'{0,1,0,0,1,0}, '{0,0,1,0,0,1}, '{0,0,1,1,1,0},
    '{0,1,0,1,0,1}, '{1,0,0,0,1,0}, '{2,1,1,0,0,1}, '{3,1,0,0,0,0},
    '{0,1,0,0,1,0}};

  pin_source src (.clk(clk), .cmd(cmd), .pins(pins));
  scan_dff_async_set_reset dut (.CORE_CLK(clk), .RST(rst),
    .EDGE_CLOCK(pins[0]), .DATA_IN(pins[1]), .SCAN_SERIAL_IN(pins[2]),
    .SCAN_SELECT(pins[3]), .ASYNC_PRESET_LOW(pins[4]),
    .ASYNC_CLEAR_LOW(pins[5]), .TRUE_OUT(q), .INVERTED_OUT(qn));

  initial forever #2.5 clk = ~clk;

  // a hang is cut short well above the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task chk(input logic eq, input logic eqn);
    checked++;
    if (q !== eq || qn !== eqn)
    begin
      miscompares++;
      $display("Error at %0t: out %b%b want %b%b", $time, q, qn, eq, eqn);
    end
  endtask

  // clock and control pulses stay well above the two-cycle minimum
  task run(input row_t r);
    cmd[3:1] <= {r.sel, r.s, r.d};
    cyc(5);
    if (r.op == 0)
      cmd[0] <= 1'h1;
    else
      cmd[5:4] <= ~r.op;
    cyc(6);
    cmd <= {2'h3, cmd[3:1], 1'h0};
    cyc(9);
    chk(r.q, r.qn);
  endtask

  task report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    cyc(8);
    rst = 1'h0;
    cyc(4);
    foreach (rows[i])
      run(rows[i]);
    // edge while preset is low must be lost, not deferred
    cmd <= 6'h20;
    cyc(5);
    cmd <= 6'h21;
    cyc(5);
    cmd <= 6'h30;
    cyc(9);
    chk(1'h1, 1'h0);
    // scan path selected with a zero waiting: a stray capture would show
    cmd <= 6'h38;
    cyc(12);
    chk(1'h1, 1'h0);
    // mid-run reset clears the cell, then the first edge after it captures
    rst = 1'h1;
    cyc(2);
    chk(1'h0, 1'h1);
    rst = 1'h0;
    cyc(4);
    run(rows[0]);
    report_and_stop();
  end
endmodule // test_scan_dff_async_set_reset

bind scan_dff_async_set_reset ff_cell_chk chk (.CORE_CLK(CORE_CLK),
  .RST(RST), .EDGE_CLOCK(EDGE_CLOCK), .DATA_IN(DATA_IN),
  .SCAN_SERIAL_IN(SCAN_SERIAL_IN), .SCAN_SELECT(SCAN_SELECT),
  .ASYNC_PRESET_LOW(ASYNC_PRESET_LOW), .ASYNC_CLEAR_LOW(ASYNC_CLEAR_LOW),
  .TRUE_OUT(TRUE_OUT), .INVERTED_OUT(INVERTED_OUT));
